// File: rtl/gpi_pkg.sv
// Package for the pin interrupt status block: register offsets, widths,
// reset values and the register port data width.
// Assumes an 8-bit register command interpreter in front of the block.
package gpi_pkg;

  // Register port widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Pin group widths
  localparam int unsigned COL_PINS = 8;
  localparam int unsigned RLO_PINS = 8;
  localparam int unsigned RHI_PINS = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_COL_IRQ_ENABLE         = 8'hD2;
  localparam logic [ADDR_W-1:0] OFS_ROW_LOW_IRQ_ENABLE     = 8'hD3;
  localparam logic [ADDR_W-1:0] OFS_ROW_HIGH_IRQ_ENABLE    = 8'hD4;
  localparam logic [ADDR_W-1:0] OFS_COL_RAW_IRQ_STATUS     = 8'hD6;
  localparam logic [ADDR_W-1:0] OFS_ROW_LOW_RAW_STATUS     = 8'hD7;
  localparam logic [ADDR_W-1:0] OFS_ROW_HIGH_RAW_STATUS    = 8'hD8;
  localparam logic [ADDR_W-1:0] OFS_COL_MASKED_STATUS      = 8'hD9;
  localparam logic [ADDR_W-1:0] OFS_ROW_LOW_MASKED_STATUS  = 8'hDA;
  localparam logic [ADDR_W-1:0] OFS_ROW_HIGH_MASKED_STATUS = 8'hDB;
  localparam logic [ADDR_W-1:0] OFS_COL_IRQ_CLEAR          = 8'hDC;
  localparam logic [ADDR_W-1:0] OFS_ROW_LOW_IRQ_CLEAR      = 8'hDD;
  localparam logic [ADDR_W-1:0] OFS_ROW_HIGH_IRQ_CLEAR     = 8'hDE;

  // Reset values
  localparam logic [DATA_W-1:0] ENABLE_RST   = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST    = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_VAL = 8'h00;
  localparam logic [DATA_W-1:0] POLARITY_RST = 8'hFF;

  // Sense type encoding
  localparam logic SENSE_EDGE  = 1'b0;
  localparam logic SENSE_LEVEL = 1'b1;

endpackage : gpi_pkg

// File: rtl/gpi_pin_detect.sv
// One pin's interrupt condition detector and raw status flag.
// Assumes the pin level is synchronous to clk_sys.
`timescale 1ns/100ps
module gpi_pin_detect (
  // Clock, reset, enable
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic clk_en,
  // Pin and its configuration
  input  wire logic pin,
  input  wire logic sense_type,
  input  wire logic edge_polarity,
  input  wire logic both_edges,
  // Clear strobe and status
  input  wire logic clear,
  output logic      raw
);

  logic prev_r;
  logic primed_r;
  logic raw_r;
  logic rise;
  logic fall;
  logic edge_hit;
  logic raw_nxt;

  assign rise = primed_r & pin & ~prev_r;
  assign fall = primed_r & ~pin & prev_r;

  always_comb begin
    if (both_edges) begin
      edge_hit = rise | fall;
    end else if (edge_polarity) begin
      edge_hit = rise;
    end else begin
      edge_hit = fall;
    end
  end

  always_comb begin
    if (sense_type == gpi_pkg::SENSE_LEVEL) begin
      raw_nxt = (pin == edge_polarity);
    end else begin
      // New edge beats a clear in the same cycle
      raw_nxt = edge_hit | (raw_r & ~clear);
    end
  end

  // Previous pin level; first cycle only primes it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prev_r   <= 1'b0;
      primed_r <= 1'b0;
    end else if (clk_en) begin
      prev_r   <= pin;
      primed_r <= 1'b1;
    end
  end

  // Raw status flag
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      raw_r <= 1'b0;
    end else if (clk_en) begin
      raw_r <= raw_nxt;
    end
  end

  assign raw = raw_r;

endmodule : gpi_pin_detect

// File: rtl/gpi_irq_status.sv
// Pin interrupt enable, raw status, masked status and clear registers
// for the column, low row and high row pin groups.
// Assumes a byte-wide register port from the serial slave's command
// interpreter and pin levels synchronous to clk_sys.
`timescale 1ns/100ps

module gpi_irq_status #(
  parameter int unsigned COL_W = gpi_pkg::COL_PINS,
  parameter int unsigned RLO_W = gpi_pkg::RLO_PINS,
  parameter int unsigned RHI_W = gpi_pkg::RHI_PINS
) (
  // Clock, reset, enable
  input  wire logic                        clk_sys,
  input  wire logic                        arst_n,
  input  wire logic                        clk_en,
  // Pin levels
  input  wire logic [COL_W-1:0]            column_pins,
  input  wire logic [RLO_W-1:0]            row_pins_low,
  input  wire logic [RHI_W-1:0]            row_pins_high,
  // Per pin sense configuration, column / low row / high row concatenated
  input  wire logic [COL_W+RLO_W+RHI_W-1:0] sense_type_setting,
  input  wire logic [COL_W+RLO_W+RHI_W-1:0] edge_polarity_setting,
  input  wire logic [COL_W+RLO_W+RHI_W-1:0] both_edges_setting,
  // Register port
  input  wire logic [gpi_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic [gpi_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_rd,
  output logic      [gpi_pkg::DATA_W-1:0]  reg_rdata,
  output logic                             reg_rvalid,
  // Host interrupt request
  output logic                             host_irq
);

  localparam int unsigned NPIN = COL_W + RLO_W + RHI_W;
  localparam int unsigned DW   = gpi_pkg::DATA_W;

  // Each group must fit one register byte
  if (COL_W < 1 || COL_W > DW) begin : g_bad_col_w
    $error("Column group width must lie between 1 and the register width");
  end
  if (RLO_W < 1 || RLO_W > DW) begin : g_bad_rlo_w
    $error("Low row group width must lie between 1 and the register width");
  end
  if (RHI_W < 1 || RHI_W > DW) begin : g_bad_rhi_w
    $error("High row group width must lie between 1 and the register width");
  end

  // Enable registers
  logic [COL_W-1:0] column_enable_bits_r;
  logic [RLO_W-1:0] row_low_enable_bits_r;
  logic [RHI_W-1:0] row_high_enable_bits_r;

  // Status
  logic [NPIN-1:0]  pins_all;
  logic [NPIN-1:0]  clear_all;
  logic [NPIN-1:0]  raw_all;
  logic [NPIN-1:0]  enable_all;
  logic [NPIN-1:0]  masked_all;

  logic [COL_W-1:0] column_raw_bits;
  logic [RLO_W-1:0] row_low_raw_bits;
  logic [RHI_W-1:0] row_high_raw_bits;
  logic [COL_W-1:0] column_masked_bits;
  logic [RLO_W-1:0] row_low_masked_bits;
  logic [RHI_W-1:0] row_high_masked_bits;

  // Clear strobes
  logic [COL_W-1:0] column_clear_bits;
  logic [RLO_W-1:0] row_low_clear_bits;
  logic [RHI_W-1:0] row_high_clear_bits;

  // Read path
  logic [DW-1:0]    rdata_r;
  logic [DW-1:0]    rdata_nxt;
  logic             rvalid_r;
  logic             irq_r;

  logic             wr_go;
  logic             rd_go;

  assign wr_go = clk_en & reg_wr;
  assign rd_go = clk_en & reg_rd;

  // Register address decode, one hit per mapped offset
  logic             hit_col_enable;
  logic             hit_rlo_enable;
  logic             hit_rhi_enable;
  logic             hit_col_raw;
  logic             hit_rlo_raw;
  logic             hit_rhi_raw;
  logic             hit_col_masked;
  logic             hit_rlo_masked;
  logic             hit_rhi_masked;
  logic             hit_col_clear;
  logic             hit_rlo_clear;
  logic             hit_rhi_clear;

  assign hit_col_enable = (reg_addr == gpi_pkg::OFS_COL_IRQ_ENABLE);
  assign hit_rlo_enable = (reg_addr == gpi_pkg::OFS_ROW_LOW_IRQ_ENABLE);
  assign hit_rhi_enable = (reg_addr == gpi_pkg::OFS_ROW_HIGH_IRQ_ENABLE);
  assign hit_col_raw    = (reg_addr == gpi_pkg::OFS_COL_RAW_IRQ_STATUS);
  assign hit_rlo_raw    = (reg_addr == gpi_pkg::OFS_ROW_LOW_RAW_STATUS);
  assign hit_rhi_raw    = (reg_addr == gpi_pkg::OFS_ROW_HIGH_RAW_STATUS);
  assign hit_col_masked = (reg_addr == gpi_pkg::OFS_COL_MASKED_STATUS);
  assign hit_rlo_masked = (reg_addr == gpi_pkg::OFS_ROW_LOW_MASKED_STATUS);
  assign hit_rhi_masked = (reg_addr == gpi_pkg::OFS_ROW_HIGH_MASKED_STATUS);
  // Clear offsets are write only; a read of them falls to the zero default
  assign hit_col_clear  = (reg_addr == gpi_pkg::OFS_COL_IRQ_CLEAR);
  assign hit_rlo_clear  = (reg_addr == gpi_pkg::OFS_ROW_LOW_IRQ_CLEAR);
  assign hit_rhi_clear  = (reg_addr == gpi_pkg::OFS_ROW_HIGH_IRQ_CLEAR);

  // Write strobes; writes to read-only offsets match none and are dropped
  logic             wr_col_enable;
  logic             wr_rlo_enable;
  logic             wr_rhi_enable;
  logic             wr_col_clear;
  logic             wr_rlo_clear;
  logic             wr_rhi_clear;

  assign wr_col_enable = wr_go & hit_col_enable;
  assign wr_rlo_enable = wr_go & hit_rlo_enable;
  assign wr_rhi_enable = wr_go & hit_rhi_enable;
  assign wr_col_clear  = wr_go & hit_col_clear;
  assign wr_rlo_clear  = wr_go & hit_rlo_clear;
  assign wr_rhi_clear  = wr_go & hit_rhi_clear;

  // Column enable register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      column_enable_bits_r <= gpi_pkg::ENABLE_RST[COL_W-1:0];
    end else if (wr_col_enable) begin
      column_enable_bits_r <= reg_wdata[COL_W-1:0];
    end
  end

  // Low row enable register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      row_low_enable_bits_r <= gpi_pkg::ENABLE_RST[RLO_W-1:0];
    end else if (wr_rlo_enable) begin
      row_low_enable_bits_r <= reg_wdata[RLO_W-1:0];
    end
  end

  // High row enable register; unused high bits are dropped
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      row_high_enable_bits_r <= gpi_pkg::ENABLE_RST[RHI_W-1:0];
    end else if (wr_rhi_enable) begin
      row_high_enable_bits_r <= reg_wdata[RHI_W-1:0];
    end
  end

  // One-cycle clear strobes from writes to the clear registers
  always_comb begin
    column_clear_bits   = '0;
    row_low_clear_bits  = '0;
    row_high_clear_bits = '0;
    if (wr_col_clear) begin
      column_clear_bits = reg_wdata[COL_W-1:0];
    end
    if (wr_rlo_clear) begin
      row_low_clear_bits = reg_wdata[RLO_W-1:0];
    end
    if (wr_rhi_clear) begin
      row_high_clear_bits = reg_wdata[RHI_W-1:0];
    end
  end

  assign pins_all   = {row_pins_high, row_pins_low, column_pins};
  assign clear_all  = {row_high_clear_bits, row_low_clear_bits, column_clear_bits};
  assign enable_all = {row_high_enable_bits_r, row_low_enable_bits_r, column_enable_bits_r};

  // Per pin detectors
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      gpi_pin_detect u_det (
        .clk_sys       (clk_sys),
        .arst_n        (arst_n),
        .clk_en        (clk_en),
        .pin           (pins_all[gi]),
        .sense_type    (sense_type_setting[gi]),
        .edge_polarity (edge_polarity_setting[gi]),
        .both_edges    (both_edges_setting[gi]),
        .clear         (clear_all[gi]),
        .raw           (raw_all[gi])
      );
    end
  endgenerate

  assign masked_all = raw_all & enable_all;

  assign column_raw_bits      = raw_all[COL_W-1:0];
  assign row_low_raw_bits     = raw_all[COL_W+RLO_W-1:COL_W];
  assign row_high_raw_bits    = raw_all[NPIN-1:COL_W+RLO_W];
  assign column_masked_bits   = masked_all[COL_W-1:0];
  assign row_low_masked_bits  = masked_all[COL_W+RLO_W-1:COL_W];
  assign row_high_masked_bits = masked_all[NPIN-1:COL_W+RLO_W];

  // Readback words; zero-extension keeps the reserved high bits at zero
  logic [DW-1:0]    col_enable_word;
  logic [DW-1:0]    rlo_enable_word;
  logic [DW-1:0]    rhi_enable_word;
  logic [DW-1:0]    col_raw_word;
  logic [DW-1:0]    rlo_raw_word;
  logic [DW-1:0]    rhi_raw_word;
  logic [DW-1:0]    col_masked_word;
  logic [DW-1:0]    rlo_masked_word;
  logic [DW-1:0]    rhi_masked_word;

  assign col_enable_word = DW'(column_enable_bits_r);
  assign rlo_enable_word = DW'(row_low_enable_bits_r);
  assign rhi_enable_word = DW'(row_high_enable_bits_r);
  assign col_raw_word    = DW'(column_raw_bits);
  assign rlo_raw_word    = DW'(row_low_raw_bits);
  assign rhi_raw_word    = DW'(row_high_raw_bits);
  assign col_masked_word = DW'(column_masked_bits);
  assign rlo_masked_word = DW'(row_low_masked_bits);
  assign rhi_masked_word = DW'(row_high_masked_bits);

  // Per group pending summaries
  // Summarised per group so the request has a shallow OR tree
  logic             col_pending;
  logic             rlo_pending;
  logic             rhi_pending;

  assign col_pending = |column_masked_bits;
  assign rlo_pending = |row_low_masked_bits;
  assign rhi_pending = |row_high_masked_bits;

  // Read mux; unused high bits and unmapped offsets read zero
  always_comb begin
    rdata_nxt = gpi_pkg::UNMAPPED_VAL;
    unique case (1'b1)
      hit_col_enable: rdata_nxt = col_enable_word;
      hit_rlo_enable: rdata_nxt = rlo_enable_word;
      hit_rhi_enable: rdata_nxt = rhi_enable_word;
      hit_col_raw:    rdata_nxt = col_raw_word;
      hit_rlo_raw:    rdata_nxt = rlo_raw_word;
      hit_rhi_raw:    rdata_nxt = rhi_raw_word;
      hit_col_masked: rdata_nxt = col_masked_word;
      hit_rlo_masked: rdata_nxt = rlo_masked_word;
      hit_rhi_masked: rdata_nxt = rhi_masked_word;
      default:        rdata_nxt = gpi_pkg::UNMAPPED_VAL;
    endcase
  end

  // Read data capture
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= gpi_pkg::RDATA_RST;
    end else if (rd_go) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Read valid pulse
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_r <= 1'b0;
    end else if (clk_en) begin
      rvalid_r <= reg_rd;
    end
  end

  // Host interrupt request
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_r <= 1'b0;
    end else if (clk_en) begin
      irq_r <= col_pending | rlo_pending | rhi_pending;
    end
  end

  assign reg_rdata  = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign host_irq   = irq_r;

endmodule : gpi_irq_status

// File: verification/gpi_irq_props.sv
// Checker for the register port and interrupt request of the status block.
// Assumes it is bound onto gpi_irq_status and sees its ports only.
`timescale 1ns/100ps
module gpi_irq_chk (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       clk_en,
  // Register port and request
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       host_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic rd_ok;
  assign rd_ok = reg_rd && clk_en;
  a_read_answer_due: assert property (rd_ok |=> reg_rvalid) else $error("read not answered");
  a_rvalid_has_cause: assert property (reg_rvalid |-> $past(rd_ok) || $past(!clk_en))
    else $error("rvalid without read");
  a_rdata_holds: assert property (!rd_ok |=> $stable(reg_rdata)) else $error("rdata moved");
  a_zero_places_read: assert property (rd_ok && (reg_addr inside {8'hD5, [8'hDC:8'hDE]} || reg_addr < 8'hD2
    || reg_addr > 8'hDE) |=> reg_rdata == 8'h00) else $error("clear or unmapped read not zero");
  a_nibble_reserved: assert property (rd_ok && reg_addr inside {8'hD4, 8'hD8, 8'hDB}
    |=> reg_rdata[7:4] == 4'h0) else $error("reserved nibble set");
  a_enable_readback: assert property (reg_wr && clk_en && reg_addr == 8'hD3 ##1 !reg_wr ##1
    rd_ok && reg_addr == 8'hD3 |=> reg_rdata == $past(reg_wdata, 3)) else $error("enable readback");
  a_irq_quiet_start: assert property ($rose(arst_n) |-> !host_irq [*2]) else $error("irq after reset");
  a_write_no_answer: assert property (reg_wr && !reg_rd |=> !reg_rvalid) else $error("write answered");
  c_irq_pulse: cover property (host_irq ##1 !host_irq);
  c_raw_seen: cover property (rd_ok && reg_addr == 8'hD6 ##1 reg_rdata != 8'h00);
  c_clear_write: cover property (reg_wr && reg_addr == 8'hDC && reg_wdata != 8'h00);
endmodule : gpi_irq_chk

bind gpi_irq_status gpi_irq_chk chk (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .host_irq(host_irq));

// File: verification/gpi_host_model.sv
// Host model: byte register port master standing for the serial slave.
// Assumes rvalid comes one cycle after the read strobe is taken.
`timescale 1ns/100ps
module gpi_host_model (
  // Clock
  input wire logic        clk_sys,
  // Register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // Released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk_sys);
    d = reg_rvalid ? reg_rdata : 8'hXX;
  endtask : rd
endmodule : gpi_host_model

// File: verification/tb_top.sv
// Testbench for the pin interrupt status block.
// Assumes gpi_host_model drives the register port; pins are driven here.
`timescale 1ns/100ps
module tb_top;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic [7:0]  column_pins = 8'h00;
  logic [7:0]  row_pins_low = 8'h00;
  logic [3:0]  row_pins_high = 4'h0;
  // High row level, low row bit 1 falling, low row bit 0 both edges
  logic [19:0] sense = 20'hF0000;
  logic [19:0] pol = 20'hFFDFF;
  logic [19:0] both = 20'h00100;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, reg_rvalid, host_irq;
  int          failures = 0;
  int          num_checks = 0;
  always #5 clk_sys = ~clk_sys;
  gpi_irq_status dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .column_pins(column_pins),
    .row_pins_low(row_pins_low), .row_pins_high(row_pins_high), .sense_type_setting(sense),
    .edge_polarity_setting(pol), .both_edges_setting(both), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .host_irq(host_irq));
  gpi_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h got %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask : rchk
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int a = 8'hD2; a <= 8'hDE; a++) rchk(a[7:0], 8'h00);
    host.wr(8'hD2, 8'hA5);
    host.wr(8'hD4, 8'hFF);
    host.wr(8'hD6, 8'hFF);
    host.wr(8'hD3, 8'h5A);
    rchk(8'hD3, 8'h5A);
    rchk(8'hD2, 8'hA5);
    rchk(8'hD4, 8'h0F);
    rchk(8'hD6, 8'h00);
    @(posedge clk_sys);
    column_pins <= 8'h81;
    idle(3);
    chk("host_irq", 8'h01, {7'h00, host_irq});
    @(posedge clk_sys);
    column_pins <= 8'h00;
    idle(3);
    rchk(8'hD6, 8'h81);
    rchk(8'hD9, 8'h81);
    host.wr(8'hD2, 8'h00);
    rchk(8'hD9, 8'h00);
    rchk(8'hD6, 8'h81);
    chk("host_irq", 8'h00, {7'h00, host_irq});
    host.wr(8'hD2, 8'hA5);
    host.wr(8'hDC, 8'h00);
    rchk(8'hD6, 8'h81);
    host.wr(8'hDC, 8'h01);
    rchk(8'hD6, 8'h80);
    host.wr(8'hDC, 8'h80);
    idle(2);
    chk("host_irq", 8'h00, {7'h00, host_irq});
    // Clock enable low: a pin pulse inside the frozen span is never seen
    @(posedge clk_sys);
    clk_en <= 1'b0;
    column_pins <= 8'h01;
    idle(2);
    @(posedge clk_sys);
    column_pins <= 8'h00;
    idle(2);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rchk(8'hD6, 8'h00);
    @(posedge clk_sys);
    row_pins_low <= 8'h03;
    idle(3);
    rchk(8'hD7, 8'h01);
    host.wr(8'hDD, 8'h01);
    @(posedge clk_sys);
    row_pins_low <= 8'h00;
    idle(3);
    rchk(8'hD7, 8'h03);
    rchk(8'hDA, 8'h02);
    host.wr(8'hDD, 8'hFF);
    rchk(8'hD7, 8'h00);
    @(posedge clk_sys);
    row_pins_high <= 4'h5;
    idle(3);
    rchk(8'hD8, 8'h05);
    rchk(8'hDB, 8'h05);
    host.wr(8'hDE, 8'hFF);
    rchk(8'hD8, 8'h05);
    chk("host_irq", 8'h01, {7'h00, host_irq});
    @(posedge clk_sys);
    row_pins_high <= 4'h0;
    idle(3);
    rchk(8'hD8, 8'h00);
    chk("host_irq", 8'h00, {7'h00, host_irq});
    // High row bit 3 turned to low-level sense
    @(posedge clk_sys);
    pol <= 20'h7FDFF;
    idle(3);
    rchk(8'hD8, 8'h08);
    chk("host_irq", 8'h01, {7'h00, host_irq});
    @(posedge clk_sys);
    arst_n <= 1'b0;
    idle(2);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    rchk(8'hD2, 8'h00);
    rchk(8'hDB, 8'h00);
    finish_test();
  end
  initial begin
    #50000;
    failures++;
    finish_test();
  end
endmodule : tb_top
